// file: src/cse_state_regs.sv
// Behaviour
// RL1: 32-bit state register, moves only in supervisor
// RL2: supervisor bit resets to one
// RL3: tick exceptions recognised only when enabled
// RL4: interrupts recognised only when enabled
// RL5: cache enable bits reset to zero
// RL6: mmu enable bits reset to zero
// RL7: little endian bit selects byte order
// RL8: context enable increments context, uses shadows
// RL9: branch flag follows compare result
// RL10: carry bit follows arithmetic carry out
// RL11: overflow bit follows arithmetic overflow
// RL12: overflow raises range exception when enabled
// RL13: delay slot bit marks saved pc
// RL14: vector base bit selects high base
// RL15: fixed one bit always reads one
// RL16: user read flag opens some reads
// RL17: context id field resets to zero
// RL18: entry saves interrupted pc
// RL19: entry saves faulting effective address
// RL20: entry saves prior state register
// RL21: handler saves single set before re-enabling
// RL22: user reads fault address only if allowed
// RL23: reserved and fixed bits ignore writes
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_state_regs #(
    parameter int NSETS = 16
) (
    input  wire logic              sys_clk_i,     // core clock
    input  wire logic              reset_n_i,     // async reset, low
    input  wire logic              spr_re_i,      // move-from strobe
    input  wire logic              spr_we_i,      // move-to strobe
    input  wire cse_pkg::cse_spr_addr_t spr_addr_i, // special reg index
    input  wire cse_pkg::cse_word_t spr_wdata_i,  // move-to data
    input  wire logic              flag_we_i,     // compare done
    input  wire logic              flag_i,        // compare result
    input  wire logic              carry_we_i,    // arith done, carry
    input  wire logic              carry_i,       // carry out
    input  wire logic              ovf_we_i,      // arith done, overflow
    input  wire logic              ovf_i,         // overflow
    input  wire logic              tick_req_i,    // tick timer request
    input  wire logic              irq_req_i,     // external interrupt
    input  wire logic              exc_entry_i,   // exception entry
    input  wire cse_pkg::cse_word_t exc_pc_i,     // interrupted pc
    input  wire cse_pkg::cse_word_t exc_ea_i,     // faulting address
    input  wire logic              exc_ds_i,      // pc in delay slot
    output cse_pkg::cse_word_t     spr_rdata_o,   // move-from data
    output logic                   spr_err_o,     // access refused
    output cse_pkg::cse_word_t     state_o,       // state register
    output logic                   tick_take_o,   // tick recognised
    output logic                   irq_take_o,    // irq recognised
    output logic                   range_exc_o,   // range exception
    output cse_pkg::cse_word_t     vec_base_o,    // vector base
    output logic                   dcache_en_o,   // data cache on
    output logic                   icache_en_o,   // insn cache on
    output logic                   dmmu_en_o,     // data mmu on
    output logic                   immu_en_o,     // insn mmu on
    output logic                   little_end_o,  // lsb-first order
    output logic                   shadow_en_o    // shadow sets on
);
    import cse_pkg::*;

    localparam int IW = (NSETS > 1) ? $clog2(NSETS) : 1;
    // four index bits in the move address, so at most 16 save sets

    // ********************************
    // state
    // ********************************
    cse_word_t state_r, state_nxt;
    cse_word_t epc_r    [NSETS];
    cse_word_t epc_nxt  [NSETS];
    cse_word_t eea_r    [NSETS];
    cse_word_t eea_nxt  [NSETS];
    cse_word_t sst_r    [NSETS];
    cse_word_t sst_nxt  [NSETS];
    cse_word_t rdata_r, rdata_nxt;
    cse_word_t vec_r,   vec_nxt;
    logic      err_r,   err_nxt;
    logic      tick_r,  tick_nxt;
    logic      irq_r,   irq_nxt;
    logic      rexc_r,  rexc_nxt;

    cse_kind_t        kind;
    logic [3:0]       idx;
    logic [IW-1:0]    sel;
    logic [IW-1:0]    slot;
    logic [3:0]       cid_inc;
    logic             hit;
    logic             supv;
    logic             rd_ok;

    // ********************************
    // next values
    // ********************************
    always_comb begin
        state_nxt = state_r;
        epc_nxt   = epc_r;
        eea_nxt   = eea_r;
        sst_nxt   = sst_r;
        rdata_nxt = rdata_r;
        err_nxt   = 1'b0;
        kind      = cse_decode(spr_addr_i);
        idx       = spr_addr_i[3:0];
        sel       = idx[IW-1:0];
        cid_inc   = 4'(state_r[`CSE_CTX_HI:`CSE_CTX_LO] + 4'h1);
        supv      = state_r[`CSE_SUPV];
        hit       = (kind == CSE_K_STATE) ||
                    ((kind != CSE_K_NONE) && (int'(idx) < NSETS));
        // only the fault address opens to user reads
        rd_ok     = supv || ((kind == CSE_K_EEA) && state_r[`CSE_USER_RD]); // RL16 RL22
        // without shadow sets every exception reuses set zero
        slot      = state_r[`CSE_SHADOW_EN] ? cid_inc[IW-1:0] : '0; // RL8

        if (spr_re_i && hit) begin
            if (rd_ok) begin // RL1
                unique case (kind)
                    CSE_K_STATE: rdata_nxt = state_r;
                    CSE_K_EPC:   rdata_nxt = epc_r[sel];
                    CSE_K_EEA:   rdata_nxt = eea_r[sel];
                    CSE_K_SST:   rdata_nxt = sst_r[sel];
                    default:     rdata_nxt = '0;
                endcase
            end else begin
                rdata_nxt = '0;
                err_nxt   = 1'b1;
            end
        end else if (spr_re_i) begin
            rdata_nxt = '0;
        end

        if (spr_we_i && hit) begin
            if (supv) begin // RL1
                unique case (kind)
                    CSE_K_STATE: state_nxt = (spr_wdata_i & `CSE_STATE_WMASK) |
                                             `CSE_STATE_FIXED; // RL23
                    CSE_K_EPC:   epc_nxt[sel] = spr_wdata_i;
                    CSE_K_EEA:   eea_nxt[sel] = spr_wdata_i;
                    CSE_K_SST:   sst_nxt[sel] = spr_wdata_i;
                    default:     state_nxt = state_r;
                endcase
            end else begin
                err_nxt = 1'b1;
            end
        end

        // pipeline updates beat a same-cycle software write
        if (flag_we_i)
            state_nxt[`CSE_FLAG] = flag_i; // RL9
        if (carry_we_i)
            state_nxt[`CSE_CARRY] = carry_i; // RL10
        if (ovf_we_i)
            state_nxt[`CSE_RANGE] = ovf_i; // RL11

        // one set only without shadows: handler must empty it before re-arming
        if (exc_entry_i) begin
            epc_nxt[slot] = exc_pc_i; // RL18
            eea_nxt[slot] = exc_ea_i; // RL19
            sst_nxt[slot] = state_r; // RL20
            state_nxt[`CSE_DSLOT] = exc_ds_i; // RL13
            if (state_r[`CSE_SHADOW_EN])
                state_nxt[`CSE_CTX_HI:`CSE_CTX_LO] = cid_inc; // RL8 RL17
        end

        tick_nxt = tick_req_i & state_r[`CSE_TICK_EN]; // RL3
        irq_nxt  = irq_req_i & state_r[`CSE_IRQ_EN]; // RL4
        rexc_nxt = ovf_we_i & ovf_i & state_r[`CSE_RANGE_TRAP]; // RL12
        vec_nxt  = state_nxt[`CSE_VEC_SEL] ? `CSE_VEC_HIGH : `CSE_VEC_LOW; // RL14
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= `CSE_STATE_RESET; // RL2 RL5 RL6 RL15 RL17
            rdata_r <= '0;
            vec_r   <= `CSE_VEC_LOW;
            err_r   <= 1'b0;
            tick_r  <= 1'b0;
            irq_r   <= 1'b0;
            rexc_r  <= 1'b0;
            for (int i = 0; i < NSETS; i++) begin
                epc_r[i] <= `CSE_SAVE_RESET;
                eea_r[i] <= `CSE_SAVE_RESET;
                sst_r[i] <= `CSE_SAVE_RESET;
            end
        end else begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
            vec_r   <= vec_nxt;
            err_r   <= err_nxt;
            tick_r  <= tick_nxt;
            irq_r   <= irq_nxt;
            rexc_r  <= rexc_nxt;
            epc_r   <= epc_nxt;
            eea_r   <= eea_nxt;
            sst_r   <= sst_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign state_o      = state_r;
    assign spr_rdata_o  = rdata_r;
    assign spr_err_o    = err_r;
    assign tick_take_o  = tick_r;
    assign irq_take_o   = irq_r;
    assign range_exc_o  = rexc_r;
    assign vec_base_o   = vec_r;
    assign dcache_en_o  = state_r[`CSE_DCACHE_EN]; // RL5
    assign icache_en_o  = state_r[`CSE_ICACHE_EN]; // RL5
    assign dmmu_en_o    = state_r[`CSE_DMMU_EN]; // RL6
    assign immu_en_o    = state_r[`CSE_IMMU_EN]; // RL6
    assign little_end_o = state_r[`CSE_LITTLE_EN]; // RL7
    assign shadow_en_o  = state_r[`CSE_SHADOW_EN]; // RL8

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic quiet;
    assign quiet = !exc_entry_i && !flag_we_i && !carry_we_i && !ovf_we_i;

    a_fixed_bits: assert property (state_r[15] && (state_r[27:17] == 11'h000)) // RL15
        else $error("fixed or reserved state bits wrong");
    a_reserved_zero: assert property (state_r[27:17] == 11'h000) // RL23
        else $error("reserved state bits not zero");
    a_user_write_block: assert property (
        (!state_r[0] && spr_we_i && spr_addr_i == 11'h011 && quiet)
        |=> $stable(state_r) && spr_err_o) // RL1
        else $error("user write changed state register");
    a_sup_write_load: assert property (
        (state_r[0] && spr_we_i && spr_addr_i == 11'h011 && quiet)
        |=> state_r == (($past(spr_wdata_i) & 32'hf001_7fff) | 32'h0000_8000)) // RL23
        else $error("state write did not load");
    a_tick_gate: assert property (tick_req_i |=> tick_take_o == $past(state_r[1])) // RL3
        else $error("tick gating wrong");
    a_irq_gate: assert property (irq_req_i |=> irq_take_o == $past(state_r[2])) // RL4
        else $error("irq gating wrong");
    a_flag_update: assert property (flag_we_i |=> state_r[9] == $past(flag_i)) // RL9
        else $error("branch flag not updated");
    a_carry_update: assert property (carry_we_i |=> state_r[10] == $past(carry_i)) // RL10
        else $error("carry not updated");
    a_overflow_update: assert property (ovf_we_i |=> state_r[11] == $past(ovf_i)) // RL11
        else $error("overflow not updated");
    a_range_exc: assert property (
        range_exc_o == $past(ovf_we_i && ovf_i && state_r[12])) // RL12
        else $error("range exception wrong");
    a_range_flag: assert property (range_exc_o |-> state_r[11]) // RL12
        else $error("range exception without overflow bit");
    a_entry_pc: assert property ((exc_entry_i && !state_r[8])
        |=> epc_r[0] == $past(exc_pc_i)) // RL18
        else $error("return pc not saved");
    a_entry_ea: assert property ((exc_entry_i && !state_r[8])
        |=> eea_r[0] == $past(exc_ea_i)) // RL19
        else $error("fault address not saved");
    a_entry_state: assert property ((exc_entry_i && !state_r[8])
        |=> sst_r[0] == $past(state_r)) // RL20
        else $error("state not saved");
    a_entry_delay_slot: assert property (exc_entry_i |=> state_r[13] == $past(exc_ds_i)) // RL13
        else $error("delay slot flag wrong");
    a_entry_keeps_supv: assert property ((exc_entry_i && !spr_we_i)
        |=> state_r[0] == $past(state_r[0])) // RL2
        else $error("entry changed supervisor bit");
    a_context_step: assert property ((exc_entry_i && state_r[8]) |=>
        state_r[31:28] == 4'($past(state_r[31:28]) + 4'h1)) // RL8
        else $error("context id did not step");

    // shadow sets: context zero saves into set one
    a_shadow_pc: assert property ((exc_entry_i && state_r[8] && state_r[31:28] == 4'h0)
        |=> epc_r[1] == $past(exc_pc_i)) // RL8
        else $error("shadow return pc not saved");
    a_shadow_state: assert property ((exc_entry_i && state_r[8] && state_r[31:28] == 4'h0)
        |=> sst_r[1] == $past(state_r)) // RL8
        else $error("shadow state not saved");
    a_user_ea_read: assert property (
        (spr_re_i && !state_r[0] && spr_addr_i[10:4] == 7'h03 && !spr_we_i)
        |=> spr_err_o == !$past(state_r[16])) // RL22
        else $error("user fault address read gating wrong");
    a_user_ea_data: assert property (
        (spr_re_i && !state_r[0] && state_r[16] && spr_addr_i == 11'h031 && !spr_we_i)
        |=> spr_rdata_o == $past(eea_r[1])) // RL22
        else $error("user fault address read data wrong");
    a_read_state: assert property ((spr_re_i && state_r[0] && spr_addr_i == 11'h011)
        |=> spr_rdata_o == $past(state_r) && !spr_err_o) // RL1
        else $error("state read data wrong");
    a_user_state_read: assert property ((spr_re_i && !state_r[0] && spr_addr_i == 11'h011)
        |=> spr_err_o && spr_rdata_o == 32'h0) // RL16
        else $error("user state read not refused");
    a_err_cause: assert property (spr_err_o |-> $past(spr_re_i || spr_we_i)) // RL1
        else $error("refusal without access");
    a_vector_base: assert property (vec_base_o == (state_r[14] ? 32'hf000_0000 : 32'h0)) // RL14
        else $error("vector base mismatch");

    c_entry_shadow: cover property (exc_entry_i && state_r[8] ##1 exc_entry_i);
    c_user_refused: cover property (spr_we_i && !state_r[0] ##1 spr_err_o);
    c_range_raised: cover property (ovf_we_i && ovf_i && state_r[12] ##1 range_exc_o);
    c_drop_to_user: cover property (state_r[0] ##1 !state_r[0]);
    c_flag_beats_write: cover property (flag_we_i && spr_we_i && spr_addr_i == 11'h011);

endmodule

// file: src/cse_regs.svh
`ifndef CSE_REGS_SVH
`define CSE_REGS_SVH

// special-register indices of the move instructions
`define CSE_STATE_ADDR    11'h011
`define CSE_EPC_BASE      11'h020
`define CSE_EEA_BASE      11'h030
`define CSE_SST_BASE      11'h040

// state register field positions
`define CSE_SUPV          0
`define CSE_TICK_EN       1
`define CSE_IRQ_EN        2
`define CSE_DCACHE_EN     3
`define CSE_ICACHE_EN     4
`define CSE_DMMU_EN       5
`define CSE_IMMU_EN       6
`define CSE_LITTLE_EN     7
`define CSE_SHADOW_EN     8
`define CSE_FLAG          9
`define CSE_CARRY         10
`define CSE_RANGE         11
`define CSE_RANGE_TRAP    12
`define CSE_DSLOT         13
`define CSE_VEC_SEL       14
`define CSE_FIXED_ONE     15
`define CSE_USER_RD       16
`define CSE_CTX_HI        31
`define CSE_CTX_LO        28

// reset values and masks
`define CSE_STATE_RESET   32'h0000_8001
`define CSE_STATE_WMASK   32'hf001_7fff
`define CSE_STATE_FIXED   32'h0000_8000
`define CSE_SAVE_RESET    32'h0000_0000
`define CSE_VEC_LOW       32'h0000_0000
`define CSE_VEC_HIGH      32'hf000_0000

`endif

// file: src/cse_pkg.sv
`include "cse_regs.svh"

package cse_pkg;
    typedef logic [31:0] cse_word_t;
    typedef logic [10:0] cse_spr_addr_t;
    typedef enum logic [2:0] {
        CSE_K_NONE,
        CSE_K_STATE,
        CSE_K_EPC,
        CSE_K_EEA,
        CSE_K_SST
    } cse_kind_t;

    function automatic cse_kind_t cse_decode(input cse_spr_addr_t a);
        cse_kind_t k;
        k = CSE_K_NONE;
        if (a == `CSE_STATE_ADDR)
            k = CSE_K_STATE;
        else if (a[10:4] == 7'(`CSE_EPC_BASE >> 4))
            k = CSE_K_EPC;
        else if (a[10:4] == 7'(`CSE_EEA_BASE >> 4))
            k = CSE_K_EEA;
        else if (a[10:4] == 7'(`CSE_SST_BASE >> 4))
            k = CSE_K_SST;
        return k;
    endfunction
endpackage

// file: verif/cse_pipe_model.sv
`timescale 1ns/1ps
// ****************
// pipeline side of the state block
// ****************
module cse_pipe_model (
    input  wire logic         sys_clk_i, // core clock
    output logic [5:0]        upd_o,     // flag, carry, overflow: strobe then value
    output logic [1:0]        req_o,     // {tick,irq} levels
    output logic              ent_o,     // exception entry pulse
    output cse_pkg::cse_word_t pc_o,     // interrupted pc
    output cse_pkg::cse_word_t ea_o,     // faulting address
    output logic              ds_o       // delay slot
);
    import cse_pkg::*;
    initial begin
        upd_o = 6'h00;
        req_o = 2'h0;
        ent_o = 1'b0;
        pc_o  = 32'h0000_0000;
        ea_o  = 32'h0000_0000;
        ds_o  = 1'b0;
    end
    task automatic arith(input logic f, input logic c, input logic o);
        @(posedge sys_clk_i);
        #1 upd_o = {1'b1, f, 1'b1, c, 1'b1, o};
        @(posedge sys_clk_i);
        #1 upd_o = 6'h00;
    endtask
    task automatic levels(input logic [1:0] v);
        @(posedge sys_clk_i);
        #1 req_o = v;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic enter(input cse_word_t pc, input cse_word_t ea, input logic ds);
        @(posedge sys_clk_i);
        #1 ent_o = 1'b1;
        pc_o = pc;
        ea_o = ea;
        ds_o = ds;
        @(posedge sys_clk_i);
        // released lines must not keep the sampled value
        #1 ent_o = 1'b0;
        pc_o = ~pc;
        ea_o = ~ea;
        ds_o = ~ds;
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cse_pkg::*;
    localparam cse_spr_addr_t ST = 11'h011;
    logic           clk, rst_n, re, we, err, tick_take, irq_take, range_exc;
    logic           ent, ds;
    logic [5:0]     upd;
    wire  [5:0]     en;
    logic [1:0]     req;
    cse_spr_addr_t  addr;
    cse_word_t      wdata, rdata, state, vec, pc, ea;
    int             failures = 0;
    int             checks = 0;
    cse_pipe_model pm_u (.sys_clk_i(clk), .upd_o(upd), .req_o(req), .ent_o(ent),
                         .pc_o(pc), .ea_o(ea), .ds_o(ds));
    cse_state_regs dut_u (
        .sys_clk_i   (clk),
        .reset_n_i   (rst_n),
        .spr_re_i    (re),
        .spr_we_i    (we),
        .spr_addr_i  (addr),
        .spr_wdata_i (wdata),
        .flag_we_i   (upd[5]),
        .flag_i      (upd[4]),
        .carry_we_i  (upd[3]),
        .carry_i     (upd[2]),
        .ovf_we_i    (upd[1]),
        .ovf_i       (upd[0]),
        .tick_req_i  (req[1]),
        .irq_req_i   (req[0]),
        .exc_entry_i (ent),
        .exc_pc_i    (pc),
        .exc_ea_i    (ea),
        .exc_ds_i    (ds),
        .spr_rdata_o (rdata),
        .spr_err_o   (err),
        .state_o     (state),
        .tick_take_o (tick_take),
        .irq_take_o  (irq_take),
        .range_exc_o (range_exc),
        .vec_base_o  (vec),
        .dcache_en_o (en[0]),
        .icache_en_o (en[1]),
        .dmmu_en_o   (en[2]),
        .immu_en_o   (en[3]),
        .little_end_o(en[4]),
        .shadow_en_o (en[5])
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************
    // access tasks
    // ****************
    task automatic chk(input string n, input cse_word_t e, input cse_word_t g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdx(input string n, input cse_spr_addr_t a, input cse_word_t e,
                       input logic ee);
        @(posedge clk);
        #1 re = 1'b1;
        addr = a;
        @(posedge clk);
        #1 re = 1'b0;
        chk(n, e, rdata);
        chk({n, " err"}, cse_word_t'(ee), cse_word_t'(err));
    endtask
    task automatic wr(input cse_spr_addr_t a, input cse_word_t d);
        @(posedge clk);
        #1 we = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 we = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        rst_n = 1'b0;
        re = 1'b0;
        we = 1'b0;
        addr = 11'h000;
        wdata = 32'h0000_0000;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("state", 32'h0000_8001, state);
        chk("outs", 32'h0, {en, tick_take, irq_take, range_exc});
        chk("vector", 32'h0, vec);
        rdx("state rd", ST, 32'h0000_8001, 1'b0);
        for (int i = 0; i < 3; i++)
            rdx("save rst", cse_spr_addr_t'(32 + 16 * i), 32'h0, 1'b0);
        rdx("unmapped", 11'h7ff, 32'h0, 1'b0);
        wr(ST, 32'hffff_ffff);
        chk("state all", 32'hf001_ffff, state);
        chk("vector", 32'hf000_0000, vec);
        for (int b = 3; b < 9; b++) begin
            wr(ST, cse_word_t'(1) | (cse_word_t'(1) << b));
            chk("enable", cse_word_t'(1) << (b - 3), cse_word_t'(en));
        end
        wr(ST, 32'h0000_0001);
        pm_u.levels(2'b11);
        chk("takes off", 32'h0, {tick_take, irq_take});
        wr(ST, 32'h0000_0007);
        @(posedge clk);
        #1 chk("takes on", 32'h3, {tick_take, irq_take});
        pm_u.levels(2'b00);
        wr(ST, 32'h0000_1001);
        pm_u.arith(1'b1, 1'b1, 1'b1);
        chk("flags", 32'h0000_9e01, state);
        chk("range on", 32'h1, range_exc);
        wr(ST, 32'h0000_0001);
        pm_u.arith(1'b0, 1'b0, 1'b1);
        chk("overflow only", 32'h0000_8801, state);
        chk("range off", 32'h0, range_exc);
        // pipeline update and software write in one cycle: pipeline bits win
        fork
            wr(ST, 32'h0000_0001);
            pm_u.arith(1'b1, 1'b1, 1'b0);
        join
        chk("flag wins", 32'h0000_8601, state);
        wr(ST, 32'h0000_0001);
        pm_u.enter(32'h1234_5678, 32'h0bad_f00d, 1'b1);
        chk("entry state", 32'h0000_a001, state);
        rdx("ret pc", 11'h020, 32'h1234_5678, 1'b0);
        rdx("fault ea", 11'h030, 32'h0bad_f00d, 1'b0);
        rdx("saved st", 11'h040, 32'h0000_8001, 1'b0);
        wr(ST, 32'h0000_0105);
        pm_u.enter(32'h0000_4444, 32'h0000_5555, 1'b0);
        chk("ctx state", 32'h1000_8105, state);
        rdx("ret pc 1", 11'h021, 32'h0000_4444, 1'b0);
        rdx("saved st 1", 11'h041, 32'h0000_8105, 1'b0);
        wr(ST, 32'h0001_0000);
        chk("user", 32'h0001_8000, state);
        rdx("user ea", 11'h031, 32'h0000_5555, 1'b0);
        rdx("user pc", 11'h021, 32'h0, 1'b1);
        rdx("user state", ST, 32'h0, 1'b1);
        wr(ST, 32'h0000_0001);
        chk("user wr err", 32'h1, cse_word_t'(err));
        chk("user wr", 32'h0001_8000, state);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("rst again", 32'h0000_8001, state);
        wr(ST, 32'h0000_0000);
        rdx("no user ea", 11'h030, 32'h0, 1'b1);
        results();
    end
    initial begin
        // about 90 cycles of tests, ample margin
        #100000;
        failures++;
        results();
    end
endmodule
